// ### logic/cbic_pkg.sv
// Constants shared by the bus and interrupt control block.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
package cbic_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CLK_PER_CYCLE = 4;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------
  // Stacking
  // ----------------------------------------
  localparam logic [3:0] STACK_FULL = 4'hC;
  localparam logic [3:0] STACK_FAST = 4'h3;

  // ----------------------------------------
  // Vectors
  // ----------------------------------------
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_FAST = 16'hFFF6;
  localparam logic [15:0] VEC_IRQ = 16'hFFF8;

  typedef enum logic [1:0] {
    CBIC_KIND_NONE,
    CBIC_KIND_NMI,
    CBIC_KIND_FAST,
    CBIC_KIND_IRQ
  } cbic_kind_t;
endpackage : cbic_pkg

// ### logic/cbic_clkgen.sv
// System and quadrature clock generator with memory-ready stretch.
// Assumes ready_sync is already synchronised to clk.
module cbic_clkgen
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stretch control
  input wire logic ready_sync,
  // Clock outputs
  output logic e_out,
  output logic q_out,
  output logic cycle_end
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic e_q;
  logic e_d;
  logic q_q;
  logic q_d;

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  always_comb
  begin
    phase_d = phase_q + 2'h1; // RL15
    if (phase_q == cbic_pkg::PH_LAST && !ready_sync)
    begin
      phase_d = phase_q; // RL9
    end
    e_d = phase_d[1]; // RL12
    q_d = phase_d[1] ^ phase_d[0]; // RL13
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= 2'h0;
      e_q <= 1'b0;
      q_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      e_q <= e_d;
      q_q <= q_d;
    end
  end

  assign e_out = e_q;
  assign q_out = q_q;
  assign cycle_end = (phase_q == cbic_pkg::PH_LAST) && ready_sync;
endmodule : cbic_clkgen

// ### logic/cbic_top.sv
// Bus control and interrupt sequencing of an 8-bit processing unit.
// Assumes the core reports instruction ends, stack loads and sync waits.
// How it works
// RL1: Fast interrupt stacks only program counter and condition codes, then vector.
// RL2: Three vectored levels; taking one masks lower levels, higher stay live.
// RL3: Non-maskable request ignored from reset until first stack pointer load.
// RL4: Acknowledge output high during vector fetch so devices can vector.
// RL5: Sync wait instruction halts the core until an interrupt line acts.
// RL6: Sync acknowledge output stays high throughout that wait.
// RL7: Last-cycle indicator marks final instruction cycle; next is opcode fetch.
// RL8: Bus float input releases address and read/write outputs.
// RL9: Memory-ready low stretches the current access until released.
// RL10: Busy output high during read-modify-write sequences.
// RL11: Address is presented at the start of each processor cycle.
// RL12: System clock output runs at the processor cycle rate.
// RL13: Quadrature output marks address and data stable interval.
// RL14: Eight-bit direct page register supplies the high address byte.
// RL15: Bus timing divides the input clock by four.
// RL16: Priority: non-maskable first, then fast, then normal request.
// RL17: Last-cycle indicator lasts exactly one processor cycle per instruction.
module cbic_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Interrupt pins, active low
  input wire logic nmi_n,
  input wire logic fast_interrupt_request_n,
  input wire logic irq_n,
  // Bus control pins
  input wire logic bus_float_control,
  input wire logic slow_memory_stretch,
  // Core side
  input wire logic [15:0] core_addr,
  input wire logic core_rw,
  input wire logic core_rmw,
  input wire logic core_instr_last,
  input wire logic core_sp_load,
  input wire logic core_sync_exec,
  input wire logic core_i_mask,
  input wire logic core_f_mask,
  input wire logic core_dp_we,
  input wire logic [7:0] core_dp_wdata,
  input wire logic [7:0] core_direct_offset,
  output logic core_advance,
  output logic [15:0] direct_addr,
  output logic set_i_mask,
  output logic set_f_mask,
  output logic [1:0] int_kind,
  // Bus pins
  output logic [15:0] addr_o,
  output logic addr_oe_n,
  output logic rw_o,
  output logic rw_oe_n,
  output logic busy,
  output logic last_cycle_indicator,
  output logic int_ack,
  output logic sync_ack,
  output logic system_clock_output,
  output logic quadrature_clock_output
);
  typedef enum logic [2:0] {
    CBIC_RUN,
    CBIC_STACK,
    CBIC_VEC_HI,
    CBIC_VEC_LO,
    CBIC_SYNC
  } cbic_state_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic nmi_s;
  logic fast_s;
  logic irq_s;
  logic float_s;
  logic ready_s;
  logic cycle_end;

  assign pin_raw = {~nmi_n, ~fast_interrupt_request_n, ~irq_n, bus_float_control,
    slow_memory_stretch};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 5'h01;
      pin_s2_q <= 5'h01;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign nmi_s = pin_s2_q[4];
  assign fast_s = pin_s2_q[3];
  assign irq_s = pin_s2_q[2];
  assign float_s = pin_s2_q[1];
  assign ready_s = pin_s2_q[0];

  cbic_clkgen u_clkgen
  (
    .clk(clk),
    .rst_n(rst_n),
    .ready_sync(ready_s),
    .e_out(system_clock_output),
    .q_out(quadrature_clock_output),
    .cycle_end(cycle_end)
  );

  // ----------------------------------------
  // Non-maskable latch and direct page
  // ----------------------------------------
  logic nmi_prev_q;
  logic nmi_prev_d;
  logic nmi_armed_q;
  logic nmi_armed_d;
  logic nmi_pend_q;
  logic nmi_pend_d;
  logic nmi_clr;
  logic [7:0] dp_q;
  logic [7:0] dp_d;

  always_comb
  begin
    nmi_prev_d = nmi_s;
    nmi_armed_d = nmi_armed_q | core_sp_load; // RL3
    nmi_pend_d = nmi_pend_q;
    if (nmi_clr)
    begin
      nmi_pend_d = 1'b0;
    end
    if (nmi_armed_q && nmi_s && !nmi_prev_q)
    begin
      nmi_pend_d = 1'b1; // RL3
    end
    dp_d = core_dp_we ? core_dp_wdata : dp_q; // RL14
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_prev_q <= 1'b0;
      nmi_armed_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      dp_q <= 8'h00;
    end
    else
    begin
      nmi_prev_q <= nmi_prev_d;
      nmi_armed_q <= nmi_armed_d;
      nmi_pend_q <= nmi_pend_d;
      dp_q <= dp_d;
    end
  end

  assign direct_addr = {dp_q, core_direct_offset}; // RL14

  // ----------------------------------------
  // Interrupt sequencer
  // ----------------------------------------
  cbic_state_t state_q;
  cbic_state_t state_d;
  cbic_pkg::cbic_kind_t kind_q;
  cbic_pkg::cbic_kind_t kind_d;
  cbic_pkg::cbic_kind_t pick;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:0] vec;
  logic take;

  always_comb
  begin
    pick = cbic_pkg::CBIC_KIND_NONE;
    if (nmi_pend_q)
    begin
      pick = cbic_pkg::CBIC_KIND_NMI; // RL16
    end
    else if (fast_s && !core_f_mask)
    begin
      pick = cbic_pkg::CBIC_KIND_FAST; // RL16
    end
    else if (irq_s && !core_i_mask)
    begin
      pick = cbic_pkg::CBIC_KIND_IRQ; // RL16
    end
  end

  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    take = 1'b0;
    nmi_clr = 1'b0;
    if (cycle_end)
    begin
      case (state_q)
        CBIC_RUN:
        begin
          if (core_sync_exec)
          begin
            state_d = CBIC_SYNC; // RL5
          end
          else if (core_instr_last && pick != cbic_pkg::CBIC_KIND_NONE)
          begin
            take = 1'b1;
            kind_d = pick;
            nmi_clr = (pick == cbic_pkg::CBIC_KIND_NMI);
            cnt_d = (pick == cbic_pkg::CBIC_KIND_FAST) ? cbic_pkg::STACK_FAST :
              cbic_pkg::STACK_FULL; // RL1
            state_d = CBIC_STACK;
          end
        end
        CBIC_STACK:
        begin
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            state_d = CBIC_VEC_HI; // RL1
          end
        end
        CBIC_VEC_HI:
        begin
          state_d = CBIC_VEC_LO;
        end
        CBIC_VEC_LO:
        begin
          state_d = CBIC_RUN;
        end
        CBIC_SYNC:
        begin
          if (nmi_pend_q || fast_s || irq_s)
          begin
            state_d = CBIC_RUN; // RL5
          end
        end
        default:
        begin
          state_d = CBIC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CBIC_RUN;
      kind_q <= cbic_pkg::CBIC_KIND_NONE;
      cnt_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
    end
  end

  always_comb
  begin
    case (kind_q)
      cbic_pkg::CBIC_KIND_NMI: vec = cbic_pkg::VEC_NMI;
      cbic_pkg::CBIC_KIND_FAST: vec = cbic_pkg::VEC_FAST;
      default: vec = cbic_pkg::VEC_IRQ;
    endcase
  end

  assign core_advance = cycle_end && (state_q == CBIC_RUN) && !take && !core_sync_exec;
  assign set_i_mask = take; // RL2
  assign set_f_mask = take && (pick != cbic_pkg::CBIC_KIND_IRQ); // RL2
  assign int_kind = kind_q;

  // ----------------------------------------
  // Bus outputs, updated at cycle start; float every clock
  // ----------------------------------------
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic rw_q;
  logic rw_d;
  logic busy_q;
  logic busy_d;
  logic lic_q;
  logic lic_d;
  logic ack_q;
  logic ack_d;
  logic sack_q;
  logic sack_d;
  logic float_q;
  logic float_d;

  always_comb
  begin
    addr_d = addr_q;
    rw_d = rw_q;
    busy_d = busy_q;
    lic_d = lic_q;
    ack_d = ack_q;
    sack_d = sack_q;
    float_d = float_s; // RL8
    if (cycle_end)
    begin
      busy_d = core_rmw && (state_q == CBIC_RUN); // RL10
      lic_d = core_advance && core_instr_last; // RL17
      ack_d = (state_d == CBIC_VEC_HI) || (state_d == CBIC_VEC_LO); // RL4
      sack_d = (state_d == CBIC_SYNC); // RL6
      rw_d = (state_d == CBIC_STACK) ? 1'b0 : ((state_d == CBIC_RUN) ? core_rw : 1'b1);
      if (state_d == CBIC_VEC_HI)
      begin
        addr_d = vec; // RL11
      end
      else if (state_d == CBIC_VEC_LO)
      begin
        addr_d = vec + 16'h0001; // RL11
      end
      else
      begin
        addr_d = core_addr; // RL11
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= 16'hFFFF;
      rw_q <= 1'b1;
      busy_q <= 1'b0;
      lic_q <= 1'b0;
      ack_q <= 1'b0;
      sack_q <= 1'b0;
      float_q <= 1'b0;
    end
    else
    begin
      addr_q <= addr_d;
      rw_q <= rw_d;
      busy_q <= busy_d;
      lic_q <= lic_d;
      ack_q <= ack_d;
      sack_q <= sack_d;
      float_q <= float_d;
    end
  end

  assign addr_o = addr_q;
  assign rw_o = rw_q;
  assign addr_oe_n = float_q; // RL8
  assign rw_oe_n = float_q; // RL8
  assign busy = busy_q;
  assign last_cycle_indicator = lic_q; // RL7
  assign int_ack = ack_q;
  assign sync_ack = sack_q;
endmodule : cbic_top

// ### test/cbic_checker.sv
// Pin checks for the bus and interrupt control block.
// Assumes a bind to cbic_top, one clock, async active-low reset.
module cbic_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic bus_float_control,
  input wire logic slow_memory_stretch,
  input wire logic core_rmw,
  input wire logic core_sp_load,
  input wire logic core_sync_exec,
  input wire logic core_dp_we,
  input wire logic [7:0] core_dp_wdata,
  input wire logic [7:0] core_direct_offset,
  // Outputs watched
  input wire logic core_advance,
  input wire logic [15:0] direct_addr,
  input wire logic set_i_mask,
  input wire logic set_f_mask,
  input wire logic [1:0] int_kind,
  input wire logic [15:0] addr_o,
  input wire logic addr_oe_n,
  input wire logic rw_o,
  input wire logic rw_oe_n,
  input wire logic busy,
  input wire logic last_cycle_indicator,
  input wire logic int_ack,
  input wire logic sync_ack,
  input wire logic system_clock_output,
  input wire logic quadrature_clock_output
);
  timeunit 1ns;
  timeprecision 1ps;
  wire e = system_clock_output;
  wire q = quadrature_clock_output;
  logic armed_q;
  logic armed_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [15:0] vec(input logic [1:0] k);
    return k == 2'h1 ? cbic_pkg::VEC_NMI : k == 2'h2 ? cbic_pkg::VEC_FAST : cbic_pkg::VEC_IRQ;
  endfunction : vec
  // ----
  // Stack pointer load seen
  // ----
  always_comb armed_d = armed_q | core_sp_load;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_q <= 1'b0;
    else
      armed_q <= armed_d;
  end
  sequence s_ph0;
    !e && !q;
  endsequence
  sequence s_qwalk;
    !e ##1 (e && q) ##1 (e && !q);
  endsequence
  // ----
  // Assertions
  // ----
  a_quad_walk: assert property ($rose(q) |-> s_qwalk) else $error("quad order");
  a_eclk_low: assert property (
    $fell(e) |-> s_ph0 ##1 !e ##1 e) else $error("e rate");
  a_lci_span: assert property (
    $rose(last_cycle_indicator) |-> s_ph0 ##0 last_cycle_indicator[*4]) else $error("lci span");
  a_busy_rmw: assert property (
    $rose(busy) |-> $past(core_rmw) ##0 busy[*4]) else $error("busy");
  a_ack_vector: assert property (
    $rose(int_ack) |-> rw_o && addr_o == vec(int_kind)) else $error("vector");
  a_fast_masks: assert property (
    set_f_mask |-> set_i_mask ##1 int_kind inside {2'h1, 2'h2}) else $error("masks");
  a_irq_mask_only: assert property (
    set_i_mask && !set_f_mask |=> int_kind == 2'h3) else $error("irq mask");
  a_nmi_armed: assert property (!armed_q |-> int_kind != 2'h1) else $error("nmi early");
  a_sync_hold: assert property (
    $rose(sync_ack) |-> $past(core_sync_exec) ##0 !core_advance[*3]) else $error("sync");
  a_float_rel: assert property (
    bus_float_control[*5] |-> addr_oe_n && rw_oe_n) else $error("float");
  a_ready_hold: assert property (
    !slow_memory_stretch[*8] |-> e && !q) else $error("stretch");
  a_early_addr: assert property ($changed(addr_o) |-> s_ph0) else $error("addr late");
  a_dp_load: assert property (
    $past(core_dp_we) |-> direct_addr == {$past(core_dp_wdata), core_direct_offset})
    else $error("dp");
endmodule : cbic_checker

// ### test/cbic_mem_model.sv
// Slow memory on the far side: stretches accesses via ready.
// Assumes the block samples ready on the rising clock edge.
module cbic_mem_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic stall_en,
  // Ready to block
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int seed = 32'h4804E047;
  initial ready = 1'b1;
  always @(posedge clk)
  begin
    #1;
    if (cnt > 0)
      cnt--;
    else if (stall_en && rst_n && $random(seed) % 4 == 0)
      cnt = 1 + {$random(seed)} % 12;
    ready <= (cnt == 0);
  end
endmodule : cbic_mem_model

// ### test/cpu_bus_interrupt_control_tb_top.sv
// Bench for the bus and interrupt control block.
// Assumes package, design, checker and memory model compiled first.
module cpu_bus_interrupt_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, nmi_n = 1'b1, irq_n = 1'b1, fast_interrupt_request_n = 1'b1;
  logic bus_float_control = 1'b0, slow_memory_stretch, core_rw = 1'b1, core_rmw = 1'b0;
  logic core_instr_last = 1'b1, core_sp_load = 1'b0, core_sync_exec = 1'b0;
  logic core_i_mask = 1'b0, core_f_mask = 1'b0, core_dp_we = 1'b0;
  logic [15:0] core_addr = 16'h0000, direct_addr, addr_o;
  logic [7:0] core_dp_wdata = 8'h00, core_direct_offset = 8'h00;
  logic [1:0] int_kind;
  logic core_advance, set_i_mask, set_f_mask, addr_oe_n, rw_o, rw_oe_n, busy, int_ack;
  logic last_cycle_indicator, sync_ack, system_clock_output, quadrature_clock_output;
  logic rnd_en = 1'b0, stall_en = 1'b0;
  int bad_count = 0, n_checks = 0, seed = 32'h4804E047, n;
  always #2.5 clk = ~clk;
  cbic_top i_dut (.*);
  cbic_mem_model i_mem (.clk(clk), .rst_n(rst_n), .stall_en(stall_en),
    .ready(slow_memory_stretch));
  // ----
  // Core side stimulus
  // ----
  always @(posedge clk)
  begin
    #1;
    core_rw <= rnd_en ? 1'($random(seed)) : 1'b1;
    core_rmw <= rnd_en & 1'($random(seed));
    core_instr_last <= rnd_en ? 1'($random(seed)) : 1'b1;
    core_addr <= 16'($random(seed));
  end
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task wt(input logic w, input logic v);
    for (n = 0; (w ? sync_ack : int_ack) !== v; n++)
    begin
      if (n == 400)
      begin
        bad_count++;
        tally_and_finish;
      end
      cyc(1);
    end
  endtask : wt
  function automatic logic [15:0] exp_vec(input int k);
    return k == 1 ? cbic_pkg::VEC_NMI : k == 2 ? cbic_pkg::VEC_FAST : cbic_pkg::VEC_IRQ;
  endfunction : exp_vec
  function automatic logic [15:0] exp_stack(input int k);
    logic [15:0] bytes;
    bytes = 16'(k == 2 ? cbic_pkg::STACK_FAST : cbic_pkg::STACK_FULL);
    return bytes * 16'(cbic_pkg::CLK_PER_CYCLE);
  endfunction : exp_stack
  // Raise lines l, count stacking clocks, check vector
  task take(input logic [2:0] l, input int k);
    int c;
    c = 0;
    rnd_en = 1'b0;
    cyc(8);
    {irq_n, fast_interrupt_request_n, nmi_n} = ~l;
    for (n = 0; n < 600 && int_ack !== 1'b1; n++)
    begin
      cyc(1);
      c += int'(rw_o === 1'b0);
    end
    {irq_n, fast_interrupt_request_n, nmi_n} = 3'h7;
    if (int_ack !== 1'b1)
    begin
      bad_count++;
      tally_and_finish;
    end
    chk(int_kind, 16'(k));
    chk(addr_o, exp_vec(k));
    chk(16'(c), exp_stack(k));
    wt(1'b0, 1'b0);
  endtask : take
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cyc(8);
    nmi_n = 1'b0;
    cyc(40);
    nmi_n = 1'b1;
    cyc(40);
    chk(int_kind, 16'h0000);
    core_sp_load = 1'b1;
    cyc(1);
    core_sp_load = 1'b0;
    take(3'h1, 1);
    take(3'h2, 2);
    take(3'h4, 3);
    take(3'h6, 2);
    take(3'h7, 1);
    core_i_mask = 1'b1;
    core_f_mask = 1'b1;
    {irq_n, fast_interrupt_request_n} = 2'h0;
    cyc(40);
    {irq_n, fast_interrupt_request_n} = 2'h3;
    chk(int_kind, 16'h0001);
    cyc(8);
    core_f_mask = 1'b0;
    take(3'h2, 2);
    core_sync_exec = 1'b1;
    wt(1'b1, 1'b1);
    core_sync_exec = 1'b0;
    cyc(40);
    chk(sync_ack, 16'h0001);
    irq_n = 1'b0;
    wt(1'b1, 1'b0);
    irq_n = 1'b1;
    cyc(8);
    chk(int_kind, 16'h0002);
    core_i_mask = 1'b0;
    bus_float_control = 1'b1;
    cyc(8);
    chk({addr_oe_n, rw_oe_n}, 16'h0003);
    bus_float_control = 1'b0;
    cyc(8);
    chk({addr_oe_n, rw_oe_n}, 16'h0000);
    repeat (8)
    begin
      core_dp_wdata = 8'($random(seed));
      core_direct_offset = 8'($random(seed));
      core_dp_we = 1'b1;
      cyc(1);
      core_dp_we = 1'b0;
      chk(direct_addr, {core_dp_wdata, core_direct_offset});
      cyc(1);
    end
    rnd_en = 1'b1;
    stall_en = 1'b1;
    cyc(4000);
    tally_and_finish;
  end
endmodule : cpu_bus_interrupt_control_tb_top

bind cbic_top cbic_checker i_chk (.*);
